// ---- rtl/sev_pkg.sv ----
// shared constants and types for the status event register bank
package sev_pkg;
  // ---------------------------------------------------------------
  // word and field layout
  // ---------------------------------------------------------------
  localparam int SEV_W = 16;
  typedef logic [SEV_W-1:0] sev_word_t;

  localparam int BIT_READING_OVERFLOW = 0;
  localparam int BIT_LOW_LIMIT = 1;
  localparam int BIT_HIGH_LIMIT = 2;
  localparam int BIT_READING_AVAILABLE = 5;
  localparam int BIT_BUFFER_AVAILABLE = 7;
  localparam int BIT_BUFFER_HALF_FULL = 8;
  localparam int BIT_BUFFER_FULL = 9;

  localparam int BIT_REF_JUNCTION_FAULT = 4;
  localparam int BIT_BAD_TRIM_CONSTANT = 8;
  localparam int BIT_IGNORED_PARAMETER = 14;

  localparam int BIT_CONVERSION_ACTIVE = 4;
  localparam int BIT_DEVICE_ACTION_ACTIVE = 5;
  localparam int BIT_IDLE = 10;
  localparam int OPER_UNUSED_LO = 11;
  localparam int OPER_UNUSED_HI = 15;

  // bits that carry an event; all others read as zero, except in the enable masks
  localparam sev_word_t MEAS_DEFINED = 16'h03A7;
  localparam sev_word_t QUES_DEFINED = 16'h4110;
  localparam sev_word_t OPER_DEFINED = 16'h0430;

  localparam sev_word_t SEV_ZERO = 16'h0000;
  localparam sev_word_t ENABLE_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // query selection and answer formatting
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SEV_REG_MEAS, SEV_REG_QUES, SEV_REG_OPER} sev_reg_t;
  typedef enum logic [1:0] {SEV_Q_EVENT, SEV_Q_COND, SEV_Q_ENABLE} sev_query_t;

  localparam int SEV_BCD_DIGITS = 5;
  localparam int SEV_BCD_W = 4 * SEV_BCD_DIGITS;
  localparam logic [3:0] BCD_ADJ_MIN = 4'h5;
  localparam logic [3:0] BCD_ADJ_ADD = 4'h3;

  // trace buffer fill thresholds
  localparam int BUF_DEPTH_DEFAULT = 1024;
  localparam int BUF_AVAIL_MIN = 2;
endpackage

// ---- rtl/sev_buffer_level.sv ----
// trace buffer fill-level decoder
`timescale 1ns/1ps
`default_nettype none
module sev_buffer_level import sev_pkg::*; #(
  parameter int DEPTH = BUF_DEPTH_DEFAULT,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic [CW-1:0] fillCount, // readings now held
  output logic available,              // two or more readings
  output logic halfFull,               // half of capacity reached
  output logic full                    // no free entries
);
  localparam logic [CW-1:0] AVAIL_CNT = CW'(BUF_AVAIL_MIN);
  localparam logic [CW-1:0] HALF_CNT = CW'(DEPTH / 2);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  always_comb begin
    available = (fillCount >= AVAIL_CNT);
    halfFull = (fillCount >= HALF_CNT);
    full = (fillCount >= FULL_CNT);
  end
endmodule
`default_nettype wire

// ---- rtl/sev_event_reg.sv ----
// one event register with condition tracking, enable mask and summary
`timescale 1ns/1ps
`default_nettype none
module sev_event_reg import sev_pkg::*; #(
  parameter sev_word_t DEFINED = MEAS_DEFINED
) (
  input wire logic clk_sys,          // system clock
  input wire logic rst,              // synchronous reset
  input wire logic ce,               // clock enable
  input wire sev_word_t cond,        // raw condition levels
  input wire logic clearReq,         // read-and-clear strobe
  input wire logic enableWrite,      // load enable mask
  input wire sev_word_t enableData,  // new enable mask
  output sev_word_t eventFlags,      // latched events
  output sev_word_t condNow,         // live condition register
  output sev_word_t condPrev,        // condition one step back
  output sev_word_t enableMask,      // enable register
  output logic summary               // unmasked event present
);
  typedef struct packed {
    sev_word_t flags;
    sev_word_t prev;
    sev_word_t mask;
  } sev_er_state_t;

  sev_er_state_t s;
  sev_er_state_t next_s;
  sev_word_t rise;

  always_comb begin
    next_s = s;
    rise = cond & ~s.prev & DEFINED;
    if (ce) begin
      // a rise in the clearing cycle survives the clear
      next_s.flags = (clearReq ? SEV_ZERO : s.flags) | rise;
      next_s.prev = cond & DEFINED;
      if (enableWrite) begin
        next_s.mask = enableData;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '{flags: SEV_ZERO, prev: SEV_ZERO, mask: ENABLE_RESET};
    end else begin
      s <= next_s;
    end
  end

  assign eventFlags = s.flags;
  assign condNow = cond & DEFINED;
  assign condPrev = s.prev;
  assign enableMask = s.mask;
  assign summary = |(s.flags & s.mask);
endmodule
`default_nettype wire

// ---- rtl/sev_status_events.sv ----
// measurement, questionable and operation event register bank
//
// Contract
// - event query returns contents, then clears register
// - answer is decimal of the set bits
// - overflow sets measurement bit 0
// - below low limit sets measurement bit 1
// - above high limit sets measurement bit 2
// - processed reading sets measurement bit 5
// - two or more buffered readings set bit 7
// - half-full trace buffer sets bit 8
// - full trace buffer sets bit 9
// - bad reference junction sets questionable bit 4
// - bad power-up trim sets bit 8, default used
// - trim fault stays until calibration succeeds
// - ignored parameter sets questionable bit 14
// - fault lamp lit while questionable event present
// - measuring sets operation bit 4
// - device-action stage sets operation bit 5
// - idle state sets operation bit 10
// - operation bits 11 to 15 never set
// - enable mask gates each summary bit
// - live condition register beside each event register
`timescale 1ns/1ps
`default_nettype none
module sev_status_events import sev_pkg::*; #(
  parameter int BUF_DEPTH = BUF_DEPTH_DEFAULT,
  parameter int CW = $clog2(BUF_DEPTH + 1)
) (
  input wire logic clk_sys,            // system clock, 50 MHz
  input wire logic rst,                // synchronous reset, high
  input wire logic ce,                 // clock enable, freezes state
  input wire logic overRange,          // reading beyond range
  input wire logic belowLowLimit,      // reading under lower limit
  input wire logic aboveHighLimit,     // reading over upper limit
  input wire logic readingDone,        // reading taken and processed
  input wire logic [CW-1:0] fillCount, // trace buffer readings
  input wire logic refJunctionBad,     // reference junction invalid
  input wire logic trimCheckBad,       // power-up trim check failed
  input wire logic calibrationPassed,  // calibration finished well
  input wire logic paramIgnored,       // config parameter dropped
  input wire logic measuring,          // conversion in progress
  input wire logic deviceAction,       // trigger device-action stage
  input wire logic idle,               // instrument idle
  input wire logic queryValid,         // query request
  input wire sev_query_t queryKind,    // event, condition or enable
  input wire sev_reg_t queryReg,       // which register set
  output logic queryReady,             // query can be taken
  output logic answerValid,            // answer present, one cycle while ce high
  output sev_word_t answerData,        // answer, binary
  output logic [SEV_BCD_W-1:0] answerBcd, // answer, decimal digits
  input wire logic enableWrite,        // enable mask write strobe
  input wire sev_reg_t enableReg,      // which enable register
  input wire sev_word_t enableData,    // mask value
  output logic measSummary,            // measurement summary
  output logic quesSummary,            // questionable summary
  output logic operSummary,            // operation summary
  output logic faultLamp,              // error indicator
  output logic useDefaultTrim          // default trim substituted
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum {SEV_ST_IDLE, SEV_ST_ANSWER} sev_state_t;

  typedef struct packed {
    sev_state_t state;
    logic trimFault;
    sev_word_t data;
    logic [SEV_BCD_W-1:0] bcd;
  } sev_top_state_t;

  sev_top_state_t s;
  sev_top_state_t next_s;

  sev_word_t measCond;
  sev_word_t quesCond;
  sev_word_t operCond;
  sev_word_t measEvent;
  sev_word_t quesEvent;
  sev_word_t operEvent;
  sev_word_t measLive;
  sev_word_t quesLive;
  sev_word_t operLive;
  sev_word_t measPrev;
  sev_word_t quesPrev;
  sev_word_t operPrev;
  sev_word_t measEn;
  sev_word_t quesEn;
  sev_word_t operEn;
  logic bufAvail;
  logic bufHalf;
  logic bufFull;
  logic take;
  logic takeEvent;
  logic measClr;
  logic quesClr;
  logic operClr;
  sev_word_t picked;

  // ---------------------------------------------------------------
  // binary to decimal digits
  // ---------------------------------------------------------------
  function automatic logic [SEV_BCD_W-1:0] sevToBcd(input sev_word_t bin);
    logic [SEV_BCD_W+SEV_W-1:0] acc;
    acc = {{SEV_BCD_W{1'b0}}, bin};
    for (int i = 0; i < SEV_W; i++) begin
      for (int d = 0; d < SEV_BCD_DIGITS; d++) begin
        if (acc[SEV_W + 4 * d +: 4] >= BCD_ADJ_MIN) begin
          acc[SEV_W + 4 * d +: 4] = acc[SEV_W + 4 * d +: 4] + BCD_ADJ_ADD;
        end
      end
      acc = acc << 1;
    end
    return acc[SEV_BCD_W+SEV_W-1:SEV_W];
  endfunction

  // ---------------------------------------------------------------
  // condition vectors
  // ---------------------------------------------------------------
  sev_buffer_level #(
    .DEPTH(BUF_DEPTH),
    .CW(CW)
  ) uLevel (
    .fillCount(fillCount),
    .available(bufAvail),
    .halfFull(bufHalf),
    .full(bufFull)
  );

  always_comb begin
    measCond = SEV_ZERO;
    measCond[BIT_READING_OVERFLOW] = overRange;
    measCond[BIT_LOW_LIMIT] = belowLowLimit;
    measCond[BIT_HIGH_LIMIT] = aboveHighLimit;
    measCond[BIT_READING_AVAILABLE] = readingDone;
    measCond[BIT_BUFFER_AVAILABLE] = bufAvail;
    measCond[BIT_BUFFER_HALF_FULL] = bufHalf;
    measCond[BIT_BUFFER_FULL] = bufFull;
    quesCond = SEV_ZERO;
    quesCond[BIT_REF_JUNCTION_FAULT] = refJunctionBad;
    quesCond[BIT_BAD_TRIM_CONSTANT] = s.trimFault;
    quesCond[BIT_IGNORED_PARAMETER] = paramIgnored;
    operCond = SEV_ZERO;
    operCond[BIT_CONVERSION_ACTIVE] = measuring;
    operCond[BIT_DEVICE_ACTION_ACTIVE] = deviceAction;
    operCond[BIT_IDLE] = idle;
  end

  // ---------------------------------------------------------------
  // query decode
  // ---------------------------------------------------------------
  assign queryReady = ce && (s.state == SEV_ST_IDLE);
  assign take = queryValid && queryReady;
  assign takeEvent = take && (queryKind == SEV_Q_EVENT);
  assign measClr = takeEvent && (queryReg == SEV_REG_MEAS);
  assign quesClr = takeEvent && (queryReg == SEV_REG_QUES);
  assign operClr = takeEvent && (queryReg == SEV_REG_OPER);

  sev_event_reg #(.DEFINED(MEAS_DEFINED)) uMeas (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .cond(measCond),
    .clearReq(measClr),
    .enableWrite(enableWrite && (enableReg == SEV_REG_MEAS)),
    .enableData(enableData),
    .eventFlags(measEvent),
    .condNow(measLive),
    .condPrev(measPrev),
    .enableMask(measEn),
    .summary(measSummary)
  );

  sev_event_reg #(.DEFINED(QUES_DEFINED)) uQues (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .cond(quesCond),
    .clearReq(quesClr),
    .enableWrite(enableWrite && (enableReg == SEV_REG_QUES)),
    .enableData(enableData),
    .eventFlags(quesEvent),
    .condNow(quesLive),
    .condPrev(quesPrev),
    .enableMask(quesEn),
    .summary(quesSummary)
  );

  // the operation definition mask keeps bits 11 to 15 clear
  sev_event_reg #(.DEFINED(OPER_DEFINED)) uOper (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .cond(operCond),
    .clearReq(operClr),
    .enableWrite(enableWrite && (enableReg == SEV_REG_OPER)),
    .enableData(enableData),
    .eventFlags(operEvent),
    .condNow(operLive),
    .condPrev(operPrev),
    .enableMask(operEn),
    .summary(operSummary)
  );

  // an unmapped register or kind answers zero
  always_comb begin
    picked = SEV_ZERO;
    case (queryReg)
      SEV_REG_MEAS: begin
        case (queryKind)
          SEV_Q_EVENT: picked = measEvent;
          SEV_Q_COND: picked = measLive;
          SEV_Q_ENABLE: picked = measEn;
          default: picked = SEV_ZERO;
        endcase
      end
      SEV_REG_QUES: begin
        case (queryKind)
          SEV_Q_EVENT: picked = quesEvent;
          SEV_Q_COND: picked = quesLive;
          SEV_Q_ENABLE: picked = quesEn;
          default: picked = SEV_ZERO;
        endcase
      end
      SEV_REG_OPER: begin
        case (queryKind)
          SEV_Q_EVENT: picked = operEvent;
          SEV_Q_COND: picked = operLive;
          SEV_Q_ENABLE: picked = operEn;
          default: picked = SEV_ZERO;
        endcase
      end
      default: picked = SEV_ZERO;
    endcase
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (ce) begin
      // a passed calibration beats a failed check in the same cycle
      if (calibrationPassed) begin
        next_s.trimFault = 1'b0;
      end else if (trimCheckBad) begin
        next_s.trimFault = 1'b1;
      end
      case (s.state)
        SEV_ST_IDLE: begin
          if (take) begin
            next_s.data = picked;
            next_s.bcd = sevToBcd(picked);
            next_s.state = SEV_ST_ANSWER;
          end
        end
        SEV_ST_ANSWER: begin
          next_s.state = SEV_ST_IDLE;
        end
        default: begin
          next_s.state = SEV_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '{state: SEV_ST_IDLE, trimFault: 1'b0, data: SEV_ZERO,
             bcd: {SEV_BCD_W{1'b0}}};
    end else begin
      s <= next_s;
    end
  end

  assign answerValid = (s.state == SEV_ST_ANSWER);
  assign answerData = s.data;
  assign answerBcd = s.bcd;
  assign useDefaultTrim = s.trimFault;
  // lamp follows latched or live questionable state
  assign faultLamp = (|quesEvent) || (|quesLive);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_CLEAR_ON_READ: assert property (@(posedge clk_sys) disable iff (rst)
    measClr && ((measCond & ~measPrev & MEAS_DEFINED) == SEV_ZERO)
      |=> measEvent == SEV_ZERO)
    else $error("measurement event not cleared by its query");

  AST_ANSWER_VALUE: assert property (@(posedge clk_sys) disable iff (rst)
    take |=> answerValid && answerData == $past(picked)
      && answerBcd == sevToBcd($past(picked)))
    else $error("query answer does not match register");

  AST_OVERFLOW_SETS: assert property (@(posedge clk_sys) disable iff (rst)
    ce && overRange && !measPrev[BIT_READING_OVERFLOW]
      |=> measEvent[BIT_READING_OVERFLOW])
    else $error("overflow did not latch");

  AST_LIMITS_SET: assert property (@(posedge clk_sys) disable iff (rst)
    ce && (belowLowLimit && !measPrev[BIT_LOW_LIMIT]
      || aboveHighLimit && !measPrev[BIT_HIGH_LIMIT])
      |=> measEvent[BIT_LOW_LIMIT] || measEvent[BIT_HIGH_LIMIT])
    else $error("limit event did not latch");

  AST_READING_SETS: assert property (@(posedge clk_sys) disable iff (rst)
    ce && readingDone && !measPrev[BIT_READING_AVAILABLE]
      |=> measEvent[BIT_READING_AVAILABLE])
    else $error("reading available did not latch");

  AST_BUFFER_FULL: assert property (@(posedge clk_sys) disable iff (rst)
    ce && fillCount >= CW'(BUF_DEPTH) && !measPrev[BIT_BUFFER_FULL]
      |-> measLive[BIT_BUFFER_AVAILABLE] && measLive[BIT_BUFFER_HALF_FULL]
        ##1 measEvent[BIT_BUFFER_FULL])
    else $error("buffer full did not latch with lower levels");

  AST_TRIM_HOLDS: assert property (@(posedge clk_sys) disable iff (rst)
    useDefaultTrim && !calibrationPassed |=> useDefaultTrim)
    else $error("trim fault dropped without calibration");

  AST_TRIM_RAISES: assert property (@(posedge clk_sys) disable iff (rst)
    ce && trimCheckBad && !calibrationPassed && !useDefaultTrim
      |=> (useDefaultTrim and (ce |=> quesEvent[BIT_BAD_TRIM_CONSTANT])))
    else $error("bad trim not flagged");

  AST_WARN_SETS: assert property (@(posedge clk_sys) disable iff (rst)
    ce && paramIgnored && !quesPrev[BIT_IGNORED_PARAMETER]
      |=> quesEvent[BIT_IGNORED_PARAMETER] && faultLamp)
    else $error("ignored parameter not flagged");

  AST_LAMP: assert property (@(posedge clk_sys) disable iff (rst)
    faultLamp == (refJunctionBad || paramIgnored || useDefaultTrim
      || quesEvent != SEV_ZERO))
    else $error("fault lamp disagrees with questionable state");

  AST_OPER_SETS: assert property (@(posedge clk_sys) disable iff (rst)
    ce && measuring && deviceAction && idle && operPrev == SEV_ZERO
      |=> operEvent == OPER_DEFINED)
    else $error("operation events did not latch");

  AST_OPER_UNUSED: assert property (@(posedge clk_sys) disable iff (rst)
    operEvent[OPER_UNUSED_HI:OPER_UNUSED_LO] == '0)
    else $error("unused operation bit set");

  AST_SUMMARY: assert property (@(posedge clk_sys) disable iff (rst)
    measSummary == ((measEvent & measEn) != SEV_ZERO))
    else $error("summary not gated by enable mask");

  AST_COND_LIVE: assert property (@(posedge clk_sys) disable iff (rst)
    ce |=> quesPrev == $past(quesLive))
    else $error("condition tracking lags");

  AST_EVENT_HOLDS: assert property (@(posedge clk_sys) disable iff (rst)
    !measClr |=> (measEvent & $past(measEvent)) == $past(measEvent))
    else $error("event bit lost before read");

  AST_UNDEFINED_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
    (measEvent & ~MEAS_DEFINED) == SEV_ZERO && (quesEvent & ~QUES_DEFINED) == SEV_ZERO)
    else $error("undefined event bit set");
endmodule
`default_nettype wire

// ---- test/sev_host_model.sv ----
// host model: issues status queries and collects the answers
`timescale 1ns/1ps
`default_nettype none
module sev_host_model import sev_pkg::*; (
  input wire logic clk_sys,                   // system clock
  input wire logic queryReady,                // device can take a query
  input wire logic answerValid,               // answer strobe
  input wire sev_word_t answerData,           // binary answer
  input wire logic [SEV_BCD_W-1:0] answerBcd, // decimal answer
  output logic queryValid,                    // query request
  output sev_query_t queryKind,               // what to read
  output sev_reg_t queryReg                   // which register set
);
  initial begin
    queryValid = 1'b0;
    queryKind = SEV_Q_EVENT;
    queryReg = SEV_REG_MEAS;
  end

  // request is held through the take edge; afterwards the selectors show
  // inverted values so that nothing can lean on a stale selection
  task automatic query(input sev_query_t k, input sev_reg_t r, output logic v,
                       output sev_word_t d, output logic [SEV_BCD_W-1:0] b);
    int n;
    n = 0;
    @(negedge clk_sys);
    queryValid = 1'b1;
    queryKind = k;
    queryReg = r;
    while (queryReady !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    queryValid = 1'b0;
    queryKind = sev_query_t'(~k);
    queryReg = sev_reg_t'(~r);
    v = answerValid;
    d = answerData;
    b = answerBcd;
  endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench for the status event register bank
`timescale 1ns/1ps
`default_nettype none
module testbench import sev_pkg::*;;
  // small buffer keeps the fill walk short
  localparam int DEPTH = 8;
  localparam int CW = $clog2(DEPTH + 1);
  logic clk_sys, rst, ce, overRange, belowLowLimit, aboveHighLimit, readingDone;
  logic refJunctionBad, trimCheckBad, calibrationPassed, paramIgnored;
  logic measuring, deviceAction, idle, enableWrite, queryValid, queryReady, answerValid;
  logic measSummary, quesSummary, operSummary, faultLamp, useDefaultTrim;
  logic [CW-1:0] fillCount;
  sev_reg_t enableReg, queryReg;
  sev_query_t queryKind;
  sev_word_t enableData, answerData;
  logic [SEV_BCD_W-1:0] answerBcd;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  int i;
  int fills [5] = '{1, 2, 4, 7, 8};
  sev_word_t fillExp [5] = '{16'h0000, 16'h0080, 16'h0180, 16'h0180, 16'h0380};

  sev_status_events #(.BUF_DEPTH(DEPTH), .CW(CW)) dut (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .overRange(overRange),
    .belowLowLimit(belowLowLimit), .aboveHighLimit(aboveHighLimit),
    .readingDone(readingDone), .fillCount(fillCount), .refJunctionBad(refJunctionBad),
    .trimCheckBad(trimCheckBad), .calibrationPassed(calibrationPassed),
    .paramIgnored(paramIgnored), .measuring(measuring), .deviceAction(deviceAction),
    .idle(idle), .queryValid(queryValid), .queryKind(queryKind), .queryReg(queryReg),
    .queryReady(queryReady), .answerValid(answerValid), .answerData(answerData),
    .answerBcd(answerBcd), .enableWrite(enableWrite), .enableReg(enableReg),
    .enableData(enableData), .measSummary(measSummary), .quesSummary(quesSummary),
    .operSummary(operSummary), .faultLamp(faultLamp), .useDefaultTrim(useDefaultTrim)
  );

  sev_host_model host (
    .clk_sys(clk_sys), .queryReady(queryReady), .answerValid(answerValid),
    .answerData(answerData), .answerBcd(answerBcd), .queryValid(queryValid),
    .queryKind(queryKind), .queryReg(queryReg)
  );

  always #10 clk_sys = ~clk_sys;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [SEV_BCD_W-1:0] to_bcd(input sev_word_t w);
    int x;
    logic [SEV_BCD_W-1:0] r;
    x = int'(w);
    r = '0;
    for (int k = 0; k < SEV_BCD_DIGITS; k++) begin
      r[k*4 +: 4] = 4'(x % 10);
      x = x / 10;
    end
    return r;
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [19:0] g, input logic [19:0] e, input string m);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic rd(input sev_query_t k, input sev_reg_t r, input sev_word_t e);
    logic v;
    sev_word_t d;
    logic [SEV_BCD_W-1:0] b;
    host.query(k, r, v, d, b);
    chk({19'h0, v}, 20'h00001, "answer strobe");
    chk({4'h0, d}, {4'h0, e}, "answer word");
    chk(b, to_bcd(e), "answer digits");
  endtask

  task automatic wen(input sev_reg_t r, input sev_word_t m);
    enableWrite = 1'b1;
    enableReg = r;
    enableData = m;
    tick(1);
    enableWrite = 1'b0;
    enableData = ~m;
    tick(1);
  endtask

  // a hang counts as a mismatch and still reaches the report
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      $display("BAD t=%0t timeout", $time);
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    {overRange, belowLowLimit, aboveHighLimit, readingDone} = 4'h0;
    {refJunctionBad, trimCheckBad, calibrationPassed, paramIgnored} = 4'h0;
    {measuring, deviceAction, idle, enableWrite} = 4'h0;
    fillCount = '0;
    enableReg = SEV_REG_MEAS;
    enableData = 16'h0000;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    rd(SEV_Q_EVENT, SEV_REG_MEAS, 16'h0000);
    rd(SEV_Q_EVENT, SEV_REG_QUES, 16'h0000);
    rd(SEV_Q_ENABLE, SEV_REG_OPER, 16'h0000);
    $display("test reset done");
    for (i = 0; i < 5; i++) begin
      fillCount = CW'(fills[i]);
      rd(SEV_Q_COND, SEV_REG_MEAS, fillExp[i]);
    end
    {overRange, belowLowLimit, aboveHighLimit, readingDone} = 4'hF;
    tick(1);
    {overRange, belowLowLimit, aboveHighLimit, readingDone} = 4'h0;
    fillCount = '0;
    tick(1);
    rd(SEV_Q_EVENT, SEV_REG_MEAS, 16'h03A7);
    rd(SEV_Q_EVENT, SEV_REG_MEAS, 16'h0000);
    $display("test measurement done");
    wen(SEV_REG_MEAS, 16'h0020);
    readingDone = 1'b1;
    tick(1);
    readingDone = 1'b0;
    tick(1);
    chk({19'h0, measSummary}, 20'h00001, "summary unmasked");
    wen(SEV_REG_MEAS, 16'h0200);
    chk({19'h0, measSummary}, 20'h00000, "summary masked");
    rd(SEV_Q_ENABLE, SEV_REG_MEAS, 16'h0200);
    rd(SEV_Q_EVENT, SEV_REG_MEAS, 16'h0020);
    // a rise seen only while the clock enable is low must not latch
    ce = 1'b0;
    overRange = 1'b1;
    tick(2);
    overRange = 1'b0;
    ce = 1'b1;
    tick(1);
    rd(SEV_Q_EVENT, SEV_REG_MEAS, 16'h0000);
    rst = 1'b1;
    tick(1);
    rst = 1'b0;
    rd(SEV_Q_ENABLE, SEV_REG_MEAS, 16'h0000);
    $display("test enable done");
    wen(SEV_REG_QUES, 16'h4000);
    {refJunctionBad, trimCheckBad, paramIgnored} = 3'h7;
    tick(1);
    {refJunctionBad, trimCheckBad, paramIgnored} = 3'h0;
    tick(1);
    chk({19'h0, faultLamp}, 20'h00001, "lamp on");
    chk({19'h0, useDefaultTrim}, 20'h00001, "default trim");
    chk({19'h0, quesSummary}, 20'h00001, "ques summary on");
    rd(SEV_Q_EVENT, SEV_REG_QUES, 16'h4110);
    rd(SEV_Q_COND, SEV_REG_QUES, 16'h0100);
    chk({19'h0, faultLamp}, 20'h00001, "lamp held");
    calibrationPassed = 1'b1;
    tick(1);
    calibrationPassed = 1'b0;
    tick(1);
    chk({19'h0, useDefaultTrim}, 20'h00000, "trim cleared");
    chk({19'h0, faultLamp}, 20'h00000, "lamp off");
    rd(SEV_Q_EVENT, SEV_REG_QUES, 16'h0000);
    chk({19'h0, quesSummary}, 20'h00000, "ques summary off");
    $display("test questionable done");
    wen(SEV_REG_OPER, 16'h0400);
    {measuring, deviceAction, idle} = 3'h7;
    tick(1);
    rd(SEV_Q_COND, SEV_REG_OPER, 16'h0430);
    chk({19'h0, operSummary}, 20'h00001, "oper summary on");
    {measuring, deviceAction, idle} = 3'h0;
    rd(SEV_Q_EVENT, SEV_REG_OPER, 16'h0430);
    chk({19'h0, operSummary}, 20'h00000, "oper summary off");
    rd(SEV_Q_EVENT, SEV_REG_OPER, 16'h0000);
    rd(SEV_Q_EVENT, sev_reg_t'(2'h3), 16'h0000);
    $display("test operation done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
